// [logic/acmrs_core.sv]
// Executor for OR/move/literal/prescaler/return/sleep instructions with APB status
`timescale 1ns/1ps
module acmrs_core
  import acmrs_pkg::*;
#(
  parameter int PC_WIDTH = PC_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Instruction from fetch
  input wire logic instr_valid_i,
  input wire logic [OP_W-1:0] instr_i,
  output logic instr_ready_o,
  // Register file port
  input wire logic [DATA_W-1:0] file_rdata_i,
  output logic [FADDR_W-1:0] file_addr_o,
  output logic file_we_o,
  output logic [DATA_W-1:0] file_wdata_o,
  // Stack and program counter
  input wire logic [PC_WIDTH-1:0] stack_top_entry_i,
  output logic pc_load_o,
  output logic [PC_WIDTH-1:0] pc_value_o,
  // Working register and flags
  output logic [DATA_W-1:0] wreg_o,
  output logic zero_we_o,
  output logic zero_o,
  output logic prescale_we_o,
  output logic [DATA_W-1:0] prescale_cfg_o,
  // Watchdog, status bits, oscillator
  output logic watchdog_counter_clr_o,
  output logic [DATA_W-1:0] watchdog_counter_val_o,
  output logic watchdog_prescale_clr_o,
  output logic status_we_o,
  output logic timeout_status_n_o,
  output logic powerdown_status_n_o,
  output logic osc_stop_o,
  input wire logic wake_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  // Elaboration-time check of the pc width
  if (PC_WIDTH < 9 || PC_WIDTH > 16) begin : g_chk
    $error("acmrs_core: PC_WIDTH must be 9..16");
  end

  acmrs_state_t state_q;
  acmrs_state_t state_d;
  logic [OP_W-1:0] instr_q;
  logic [FADDR_W-1:0] faddr_q;
  logic [DATA_W-1:0] wreg_q;
  logic [DATA_W-1:0] wreg_d;
  logic [DATA_W-1:0] prescale_q;
  logic zero_q;
  logic timeout_n_q;
  logic powerdn_n_q;
  logic ready_q;
  logic ctrl_en_q;
  logic [CNT_W-1:0] unknown_cnt_q;
  logic file_we_q;
  logic [DATA_W-1:0] file_wdata_q;
  logic pc_load_q;
  logic [PC_WIDTH-1:0] pc_value_q;
  logic zero_we_q;
  logic prescale_we_q;
  logic wd_clr_q;
  logic status_we_q;
  logic osc_stop_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic wake_sync;

  // Decoded class of the instruction in execution
  logic op_or;
  logic op_store;
  logic op_move;
  logic op_idle;
  logic op_lit;
  logic op_prescale;
  logic op_ret;
  logic op_sleep;
  logic op_unknown;

  acmrs_dec u_dec (
    .instr_i(instr_q),
    .or_wreg_into_file_o(op_or),
    .store_wreg_to_file_o(op_store),
    .move_file_value_o(op_move),
    .idle_instruction_o(op_idle),
    .load_literal_wreg_o(op_lit),
    .prescale_load_o(op_prescale),
    .return_with_literal_o(op_ret),
    .sleep_o(op_sleep),
    .unknown_o(op_unknown)
  );

  // Wake-up arrives from pins, so it is synchronised
  acmrs_sync u_wake (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(wake_i),
    .sync_o(wake_sync)
  );

  // Handshake and phase decode
  wire accept = ready_q && instr_valid_i;
  wire in_exec = state_q == ST_EXEC;
  wire dest_file = instr_q[DEST_BIT];

  // Datapath: OR result or plain file value
  wire [DATA_W-1:0] or_result = wreg_q | file_rdata_i;
  wire [DATA_W-1:0] alu_result = op_or ? or_result : file_rdata_i;
  wire alu_zero = alu_result == '0;
  wire [DATA_W-1:0] literal = instr_q[DATA_W-1:0];

  // Per-instruction effects, valid only in the execute phase
  wire fd_op = op_or || op_move;
  wire to_file = in_exec && ((fd_op && dest_file) || op_store);
  wire to_wreg_alu = in_exec && fd_op && !dest_file;
  wire to_wreg_lit = in_exec && (op_lit || op_ret);
  wire set_zero = in_exec && fd_op;
  wire load_prescale = in_exec && op_prescale;
  wire do_return = in_exec && op_ret;
  wire go_sleep = in_exec && op_sleep;
  wire file_data_sel = op_store;
  wire [DATA_W-1:0] file_data = file_data_sel ? wreg_q : alu_result;

  // APB decode; write lands at the edge where pready is seen high
  wire apb_access = psel_i && penable_i;
  wire apb_done = apb_access && pready_q;
  wire apb_wr = apb_done && pwrite_i;
  wire hit_ctrl = paddr_i == OFF_CTRL;
  wire hit_wreg = paddr_i == OFF_WREG;
  wire hit_pres = paddr_i == OFF_PRESCALE;
  wire hit_stat = paddr_i == OFF_STATUS;
  wire apb_mapped = hit_ctrl || hit_wreg || hit_pres || hit_stat;
  // Software may only overwrite wreg while no instruction is in flight
  wire sw_wreg_wr = apb_wr && hit_wreg && state_q == ST_IDLE && !accept;

  // Read mux, narrow fields sit in the low bits
  wire [31:0] rd_ctrl = {31'h0000_0000, ctrl_en_q};
  wire [31:0] rd_wreg = {24'h00_0000, wreg_q};
  wire [31:0] rd_pres = {24'h00_0000, prescale_q};
  wire [31:0] rd_stat = {16'h0000, unknown_cnt_q, 1'b0, osc_stop_q,
    powerdn_n_q, timeout_n_q, zero_q, state_q};
  wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
                        hit_wreg ? rd_wreg :
                        hit_pres ? rd_pres :
                        hit_stat ? rd_stat : 32'h0000_0000;

  // Working register next value; flags are never touched by literal loads
  always_comb begin
    wreg_d = wreg_q;
    if (to_wreg_alu) begin
      wreg_d = alu_result;
    end else if (to_wreg_lit) begin
      wreg_d = literal;
    end else if (sw_wreg_wr) begin
      wreg_d = pwdata_i[DATA_W-1:0];
    end
  end

  // Sequencer: one execute phase per instruction, return adds two flushed cycles
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (op_ret) begin
          state_d = ST_FLUSH_A;
        end else if (op_sleep) begin
          state_d = ST_SLEEP;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_FLUSH_A: begin
        state_d = ST_FLUSH_B;
      end
      ST_FLUSH_B: begin
        state_d = ST_IDLE;
      end
      ST_SLEEP: begin
        // Oscillator stays off until the wake-up condition
        if (wake_sync) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer state and fetch handshake
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
      instr_q <= ENC_IDLE;
      faddr_q <= '0;
    end else if (ce_i) begin
      state_q <= state_d;
      ready_q <= state_d == ST_IDLE && !accept && ctrl_en_q;
      if (accept) begin
        instr_q <= instr_i;
        faddr_q <= instr_i[FADDR_W-1:0];
      end
    end
  end

  // Architectural registers held by this block
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wreg_q <= WREG_RST;
      prescale_q <= PRESCALE_RST;
      zero_q <= 1'b0;
    end else if (ce_i) begin
      wreg_q <= wreg_d;
      if (load_prescale) begin
        prescale_q <= wreg_q;
      end
      if (set_zero) begin
        zero_q <= alu_zero;
      end
    end
  end

  // One-cycle strobes to the register file, stack and flag logic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      file_we_q <= 1'b0;
      file_wdata_q <= '0;
      zero_we_q <= 1'b0;
      prescale_we_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_value_q <= '0;
    end else if (ce_i) begin
      file_we_q <= to_file;
      zero_we_q <= set_zero;
      prescale_we_q <= load_prescale;
      pc_load_q <= do_return;
      if (to_file) begin
        file_wdata_q <= file_data;
      end
      if (do_return) begin
        pc_value_q <= stack_top_entry_i;
      end
    end
  end

  // Power-down effects; the pin change wake flag has no write path here
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_clr_q <= 1'b0;
      status_we_q <= 1'b0;
      timeout_n_q <= STAT_N_RST;
      powerdn_n_q <= STAT_N_RST;
      osc_stop_q <= 1'b0;
    end else if (ce_i) begin
      wd_clr_q <= go_sleep;
      status_we_q <= go_sleep;
      if (go_sleep) begin
        timeout_n_q <= TIMEOUT_N_SLEEP;
        powerdn_n_q <= POWERDN_N_SLEEP;
      end
      osc_stop_q <= state_d == ST_SLEEP;
    end
  end

  // Count of opcodes outside this group, run as idle cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unknown_cnt_q <= '0;
    end else if (ce_i) begin
      if (in_exec && op_unknown) begin
        unknown_cnt_q <= unknown_cnt_q + CNT_W'(1);
      end
    end
  end

  // APB slave: one wait state, then a one-cycle pready
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      ctrl_en_q <= CTRL_EN_RST;
    end else if (ce_i) begin
      pready_q <= apb_access && !pready_q;
      if (apb_access && !pready_q) begin
        pslverr_q <= !apb_mapped;
        prdata_q <= pwrite_i ? 32'h0000_0000 : rd_data;
      end else begin
        pslverr_q <= 1'b0;
      end
      if (apb_wr && hit_ctrl) begin
        ctrl_en_q <= pwdata_i[CTRL_EN_BIT];
      end
    end
  end

  // Outputs straight from flip-flops
  assign instr_ready_o = ready_q;
  assign file_addr_o = faddr_q;
  assign file_we_o = file_we_q;
  assign file_wdata_o = file_wdata_q;
  assign pc_load_o = pc_load_q;
  assign pc_value_o = pc_value_q;
  assign wreg_o = wreg_q;
  assign zero_we_o = zero_we_q;
  assign zero_o = zero_q;
  assign prescale_we_o = prescale_we_q;
  assign prescale_cfg_o = prescale_q;
  // Counter value is a constant; the strobe carries the timing
  assign watchdog_counter_clr_o = wd_clr_q;
  assign watchdog_counter_val_o = WATCHDOG_CLR_VAL;
  assign watchdog_prescale_clr_o = wd_clr_q;
  assign status_we_o = status_we_q;
  assign timeout_status_n_o = timeout_n_q;
  assign powerdown_status_n_o = powerdn_n_q;
  assign osc_stop_o = osc_stop_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
endmodule // acmrs_core

// [logic/acmrs_dec.sv]
// Opcode classifier for the executed instruction group
`timescale 1ns/1ps
module acmrs_dec
  import acmrs_pkg::*;
(
  input wire logic [OP_W-1:0] instr_i,
  output logic or_wreg_into_file_o,
  output logic store_wreg_to_file_o,
  output logic move_file_value_o,
  output logic idle_instruction_o,
  output logic load_literal_wreg_o,
  output logic prescale_load_o,
  output logic return_with_literal_o,
  output logic sleep_o,
  output logic unknown_o
);
  // Mask then compare; unused bits of literal forms are ignored
  assign or_wreg_into_file_o = (instr_i & MSK_FD) == ENC_OR;
  assign store_wreg_to_file_o = (instr_i & MSK_F) == ENC_STORE;
  assign move_file_value_o = (instr_i & MSK_FD) == ENC_MOVE;
  assign idle_instruction_o = (instr_i & MSK_FULL) == ENC_IDLE;
  assign load_literal_wreg_o = (instr_i & MSK_LIT) == ENC_LOADLIT;
  assign prescale_load_o = (instr_i & MSK_FULL) == ENC_PRESCALE;
  assign return_with_literal_o = (instr_i & MSK_LIT) == ENC_RETLIT;
  assign sleep_o = (instr_i & MSK_FULL) == ENC_SLEEP;
  // Anything outside the group is run as a do-nothing cycle
  assign unknown_o = !(or_wreg_into_file_o | store_wreg_to_file_o |
    move_file_value_o | idle_instruction_o | load_literal_wreg_o |
    prescale_load_o | return_with_literal_o | sleep_o);
endmodule // acmrs_dec

// [logic/acmrs_pkg.sv]
// Shared constants, encodings and states for the accumulator/move/return/sleep executor
package acmrs_pkg;
  localparam int OP_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int PC_W = 11;
  localparam int APB_AW = 8;
  localparam int CNT_W = 8;
  // Opcode patterns and masks
  localparam logic [11:0] MSK_FULL = 12'hFFF;
  localparam logic [11:0] MSK_FD = 12'hFC0;
  localparam logic [11:0] MSK_F = 12'hFE0;
  localparam logic [11:0] MSK_LIT = 12'hF00;
  localparam logic [11:0] ENC_IDLE = 12'h000;
  localparam logic [11:0] ENC_PRESCALE = 12'h002;
  localparam logic [11:0] ENC_SLEEP = 12'h003;
  localparam logic [11:0] ENC_STORE = 12'h020;
  localparam logic [11:0] ENC_OR = 12'h100;
  localparam logic [11:0] ENC_MOVE = 12'h200;
  localparam logic [11:0] ENC_RETLIT = 12'h800;
  localparam logic [11:0] ENC_LOADLIT = 12'hC00;
  localparam int DEST_BIT = 5;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_WREG = 8'h04;
  localparam logic [7:0] OFF_PRESCALE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  // Status register field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_Z_BIT = 3;
  localparam int ST_TIMEOUT_BIT = 4;
  localparam int ST_POWERDN_BIT = 5;
  localparam int ST_SLEEP_BIT = 6;
  localparam int ST_ILL_LSB = 8;
  localparam int CTRL_EN_BIT = 0;
  // Values after reset and on power-down
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] PRESCALE_RST = 8'hFF;
  localparam logic [7:0] WATCHDOG_CLR_VAL = 8'h00;
  localparam logic STAT_N_RST = 1'b1;
  localparam logic TIMEOUT_N_SLEEP = 1'b1;
  localparam logic POWERDN_N_SLEEP = 1'b0;
  // Executor states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_EXEC = 3'h1,
    ST_FLUSH_A = 3'h3,
    ST_FLUSH_B = 3'h2,
    ST_SLEEP = 3'h6
  } acmrs_state_t;
endpackage

// [logic/acmrs_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module acmrs_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic async_i,
  output logic sync_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  // First stage feeds only the second; output moves when stages 2 and 3 agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else if (ce_i) begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end

  assign sync_o = out_q;
endmodule // acmrs_sync

// [test/acmrs_core_asserts.sv]
// Checker for the executor's instruction effects and timing
`timescale 1ns/1ps
module acmrs_core_asserts
  import acmrs_pkg::*;
#(
  parameter int PC_WIDTH = PC_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic instr_valid_i,
  input wire logic [OP_W-1:0] instr_i,
  input wire logic instr_ready_o,
  input wire logic [DATA_W-1:0] file_rdata_i,
  input wire logic file_we_o,
  input wire logic [DATA_W-1:0] file_wdata_o,
  input wire logic [PC_WIDTH-1:0] stack_top_entry_i,
  input wire logic pc_load_o,
  input wire logic [PC_WIDTH-1:0] pc_value_o,
  input wire logic [DATA_W-1:0] wreg_o,
  input wire logic zero_we_o,
  input wire logic zero_o,
  input wire logic prescale_we_o,
  input wire logic [DATA_W-1:0] prescale_cfg_o,
  input wire logic watchdog_counter_clr_o,
  input wire logic [DATA_W-1:0] watchdog_counter_val_o,
  input wire logic watchdog_prescale_clr_o,
  input wire logic status_we_o,
  input wire logic timeout_status_n_o,
  input wire logic powerdown_status_n_o,
  input wire logic osc_stop_o,
  input wire logic wake_i
);
  // Opcode classes at the take edge
  wire take = instr_ready_o && instr_valid_i && ce_i;
  wire t_or = take && ((instr_i & MSK_FD) == ENC_OR);
  wire t_st = take && ((instr_i & MSK_F) == ENC_STORE);
  wire t_mv = take && ((instr_i & MSK_FD) == ENC_MOVE);
  wire t_lit = take && ((instr_i & MSK_LIT) == ENC_LOADLIT);
  wire t_ret = take && ((instr_i & MSK_LIT) == ENC_RETLIT);
  wire t_slp = take && (instr_i == ENC_SLEEP);
  wire t_pre = take && (instr_i == ENC_PRESCALE);
  wire t_idl = take && (instr_i == ENC_IDLE);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_or;
    t_or |-> ##2 zero_we_o && (file_we_o == $past(instr_i[DEST_BIT], 2))
      && (zero_o == (($past(wreg_o) | $past(file_rdata_i)) == 8'h00));
  endproperty
  a_or: assert property (p_or) else $error("or result wrong");
  property p_st;
    t_st |-> ##2 file_we_o && !zero_we_o && (file_wdata_o == wreg_o);
  endproperty
  a_st: assert property (p_st) else $error("store wrong");
  property p_mv;
    t_mv |-> ##2 zero_we_o && (zero_o == ($past(file_rdata_i) == 8'h00))
      && (($past(instr_i[DEST_BIT], 2) ? file_wdata_o : wreg_o) == $past(file_rdata_i));
  endproperty
  a_mv: assert property (p_mv) else $error("move wrong");
  property p_lit;
    t_lit |-> ##2 !zero_we_o && (wreg_o == $past(instr_i[7:0], 2));
  endproperty
  a_lit: assert property (p_lit) else $error("literal wrong");
  property p_pre;
    t_pre |-> ##2 prescale_we_o && !zero_we_o && (prescale_cfg_o == wreg_o);
  endproperty
  a_pre: assert property (p_pre) else $error("prescale wrong");
  property p_ret;
    t_ret |-> ##2 pc_load_o && (pc_value_o == $past(stack_top_entry_i))
      && (wreg_o == $past(instr_i[7:0], 2));
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_retlen;
    t_ret |=> !instr_ready_o [*3] ##1 instr_ready_o;
  endproperty
  a_retlen: assert property (p_retlen) else $error("return length wrong");
  property p_one;
    take && !t_ret && !t_slp |=> !instr_ready_o ##1 instr_ready_o;
  endproperty
  a_one: assert property (p_one) else $error("single cycle wrong");
  property p_slp;
    t_slp |-> ##2 watchdog_counter_clr_o && watchdog_prescale_clr_o && status_we_o
      && (watchdog_counter_val_o == 8'h00) && timeout_status_n_o && !powerdown_status_n_o;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep entry wrong");
  property p_osc;
    $fell(osc_stop_o) |-> $past(wake_i, 2) && instr_ready_o;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator woke early");
  property p_idl;
    t_idl |-> ##2 !file_we_o && !zero_we_o && !pc_load_o && !status_we_o && $stable(wreg_o);
  endproperty
  a_idl: assert property (p_idl) else $error("idle changed state");
endmodule // acmrs_core_asserts

bind acmrs_core acmrs_core_asserts #(.PC_WIDTH(PC_WIDTH)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .instr_ready_o(instr_ready_o), .file_rdata_i(file_rdata_i),
  .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .stack_top_entry_i(stack_top_entry_i),
  .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .wreg_o(wreg_o), .zero_we_o(zero_we_o),
  .zero_o(zero_o), .prescale_we_o(prescale_we_o), .prescale_cfg_o(prescale_cfg_o),
  .watchdog_counter_clr_o(watchdog_counter_clr_o),
  .watchdog_counter_val_o(watchdog_counter_val_o),
  .watchdog_prescale_clr_o(watchdog_prescale_clr_o), .status_we_o(status_we_o),
  .timeout_status_n_o(timeout_status_n_o), .powerdown_status_n_o(powerdown_status_n_o),
  .osc_stop_o(osc_stop_o), .wake_i(wake_i));

// [test/acmrs_rf_model.sv]
// Register file model on the executor's far side
`timescale 1ns/1ps
module acmrs_rf_model (
  input wire logic clk_i,
  input wire logic [4:0] addr_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [32];
  // Read is combinational so the execute cycle sees it at once
  assign rdata_o = mem_q[addr_i];
  // Write lands on the edge that samples the strobe
  always @(posedge clk_i) begin
    if (we_i) mem_q[addr_i] <= wdata_i;
  end
endmodule // acmrs_rf_model

// [test/tb.sv]
// Self-checking bench for the executor
`timescale 1ns/1ps
module tb;
  import acmrs_pkg::*;
  logic clk_i = 0, rst_n_i = 0, ce_i = 1, instr_valid_i = 0, wake_i = 0;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, seed = 32'h0001_0A40;
  logic [11:0] instr_i = 12'h000;
  logic [PC_W-1:0] stack_top_entry_i = '0, pc_value_o;
  logic [7:0] file_rdata_i, file_wdata_o, wreg_o, prescale_cfg_o, wd_val;
  logic [4:0] file_addr_o;
  logic instr_ready_o, file_we_o, pc_load_o, zero_we_o, zero_o, prescale_we_o, wd_clr, wp_clr;
  logic status_we_o, to_n, pd_n, osc_stop_o, pready_o, pslverr_o;
  int error_cnt = 0, cmp_count = 0;
  // Clock at 20 MHz
  always #25 clk_i = ~clk_i;
  acmrs_rf_model u_rf (.clk_i(clk_i), .addr_i(file_addr_o), .we_i(file_we_o),
    .wdata_i(file_wdata_o), .rdata_o(file_rdata_i));
  acmrs_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_ready_o(instr_ready_o), .file_rdata_i(file_rdata_i),
    .file_addr_o(file_addr_o), .file_we_o(file_we_o), .file_wdata_o(file_wdata_o),
    .stack_top_entry_i(stack_top_entry_i), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
    .wreg_o(wreg_o), .zero_we_o(zero_we_o), .zero_o(zero_o), .prescale_we_o(prescale_we_o),
    .prescale_cfg_o(prescale_cfg_o), .watchdog_counter_clr_o(wd_clr),
    .watchdog_counter_val_o(wd_val), .watchdog_prescale_clr_o(wp_clr),
    .status_we_o(status_we_o), .timeout_status_n_o(to_n), .powerdown_status_n_o(pd_n),
    .osc_stop_o(osc_stop_o), .wake_i(wake_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic zflag(input logic [7:0] v);
    return v == 8'h00;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Offer an opcode until taken, then stop in the cycle its strobes stand
  task automatic exe(input logic [11:0] op);
    @(posedge clk_i);
    instr_i <= op;
    instr_valid_i <= 1'h1;
    do @(posedge clk_i); while (instr_ready_o !== 1'h1);
    instr_valid_i <= 1'h0;
    @(posedge clk_i);
    #1;
  endtask
  // Count edges until the executor offers to take again
  task automatic wait_ready(output int n);
    n = 0;
    while (instr_ready_o !== 1'h1) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask
  // APB master, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    do @(posedge clk_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #1000000;
    error_cnt++;
    complete_run();
  end
  initial begin
    logic [31:0] rn, rd;
    logic [7:0] v, w, r, wv;
    logic [4:0] f;
    logic er;
    int n;
    repeat (5) @(posedge clk_i);
    check({wreg_o, prescale_cfg_o, to_n, pd_n}, {8'h00, 8'hFF, 2'h3});
    rst_n_i <= 1'h1;
    // Random store, OR and move with corner values first
    for (int i = 0; i < 16; i++) begin
      rn = rnd();
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rn[7:0];
      w = (i < 2) ? 8'h00 : rn[15:8];
      f = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : rn[20:16];
      exe(ENC_LOADLIT | {4'h0, v});
      check({wreg_o, zero_we_o}, {v, 1'h0});
      exe(ENC_STORE | {7'h0, f});
      check({file_we_o, file_wdata_o, file_addr_o, zero_we_o}, {1'h1, v, f, 1'h0});
      exe(ENC_LOADLIT | {4'h0, w});
      exe(ENC_OR | {6'h0, rn[21], f});
      r = v | w;
      wv = rn[21] ? w : r;
      check({file_we_o, zero_o, rn[21] ? file_wdata_o : wreg_o}, {rn[21], zflag(r), r});
      if (rn[21]) v = r;
      exe(ENC_MOVE | {6'h0, rn[22], f});
      if (!rn[22]) wv = v;
      check({zero_we_o, zero_o, rn[22] ? file_wdata_o : wreg_o}, {1'h1, zflag(v), v});
    end
    $display("test file ops done");
    exe(ENC_PRESCALE);
    check({prescale_we_o, prescale_cfg_o, zero_we_o}, {1'h1, wv, 1'h0});
    exe(ENC_IDLE);
    check({file_we_o, zero_we_o, pc_load_o, status_we_o, wreg_o}, {4'h0, wv});
    wait_ready(n);
    check(n, 0);
    rn = rnd();
    @(posedge clk_i);
    stack_top_entry_i <= rn[PC_W-1:0];
    exe(ENC_RETLIT | {4'h0, rn[31:24]});
    check({pc_load_o, pc_value_o, wreg_o}, {1'h1, rn[PC_W-1:0], rn[31:24]});
    wait_ready(n);
    check(n, 2);
    $display("test flow ops done");
    // An opcode outside the group runs as an idle cycle and is counted
    exe(12'hFFF);
    check({file_we_o, zero_we_o, pc_load_o, wreg_o}, {3'h0, rn[31:24]});
    exe(ENC_SLEEP);
    check({wd_clr, wp_clr, wd_val, status_we_o, to_n, pd_n}, {2'h3, 8'h00, 3'h6});
    repeat (8) @(posedge clk_i);
    check({osc_stop_o, instr_ready_o}, 2'h2);
    wake_i <= 1'h1;
    wait_ready(n);
    check(osc_stop_o, 1'h0);
    @(posedge clk_i);
    wake_i <= 1'h0;
    apb(1'h0, OFF_STATUS, 32'h0, rd, er);
    check(rd[15:4], 12'h011);
    $display("test sleep done");
    // Register access, an unmapped word and the enable bit
    apb(1'h1, OFF_WREG, {24'h0, rn[15:8]}, rd, er);
    apb(1'h0, OFF_WREG, 32'h0, rd, er);
    check({er, rd[7:0]}, {1'h0, rn[15:8]});
    apb(1'h0, OFF_PRESCALE, 32'h0, rd, er);
    check(rd[7:0], wv);
    apb(1'h0, 8'h10, 32'h0, rd, er);
    check(er, 1'h1);
    apb(1'h1, OFF_CTRL, 32'h0, rd, er);
    repeat (2) @(posedge clk_i);
    check(instr_ready_o, 1'h0);
    apb(1'h1, OFF_CTRL, 32'h1, rd, er);
    // With the clock enable low the offer must stay frozen although enabled
    ce_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    check(instr_ready_o, 1'h0);
    ce_i <= 1'h1;
    exe(ENC_STORE | 12'h005);
    check(file_wdata_o, rn[15:8]);
    $display("test register bus done");
    complete_run();
  end
endmodule // tb
